// >>> isgo_pkg.sv
package isgo_pkg;

   // Initialization sequencer states
   typedef enum logic [2:0]
   {
      ST_RESTART,
      ST_LOAD,
      ST_INIT,
      ST_CAL_WAIT,
      ST_USER
   } isgo_state_e;

   // Width of the count of start-up clock edges during initialization
   localparam int INIT_CNT_W = 8;
   // Start-up clock edges taken to finish initialization
   localparam logic [7:0] INIT_CYCLES = 8'h20;
   // Value of the initialization counter after reset
   localparam logic [7:0] INIT_CNT_RESET = 8'h00;
   // Value of synchroniser stages after reset (pins idle high)
   localparam logic [2:0] SYNC_RESET = 3'h7;

endpackage

// >>> isgo_init_status.sv
`timescale 1ns/1ns
// Operation
// - While restart input is low, status pin is left undriven.
// - After first-frame enable option loads, status pin is driven low.
// - When initialization finishes, status pin is released; user mode entered.
// - With calibration gating on, status stays low until calibration is done.
// - Override input low tri-states every user I/O pin (IO_OE), not the status pin; high lets pins behave.
// - Clear input low clears every register; high lets registers behave.
// - Each special pin acts only when its option is set; else the status, override and clear pins are user I/O.
// - With start-up clock option on, initialization steps on that clock.
module isgo_init_status
#(
   parameter int N_IO = 8
)
(
   // Clock and reset
   input  wire logic            CLK_SYS,
   input  wire logic            RESET_N,
   // Configuration progress
   input  wire logic            CONFIG_RESTART_N,
   input  wire logic            FIRST_FRAME_LOADED,
   input  wire logic            TERMINATION_CALIBRATED,
   // Option bits
   input  wire logic            OPT_INIT_DONE_EN,
   input  wire logic            OPT_CAL_GATE_EN,
   input  wire logic            OPT_OVERRIDE_EN,
   input  wire logic            OPT_CLEAR_EN,
   input  wire logic            OPT_STARTUP_CLK_EN,
   // Board pins
   input  wire logic            USER_STARTUP_CLOCK,
   input  wire logic            GLOBAL_OUTPUT_OVERRIDE_N,
   input  wire logic            GLOBAL_REGISTER_CLEAR_N,
   // Status pin, open drain
   input  wire logic            INIT_STATUS_IN,
   output logic                 INIT_STATUS_OUT,
   output logic                 INIT_STATUS_OE,
   // User fabric view
   input  wire logic [N_IO-1:0] USER_IO_OE,
   output logic      [N_IO-1:0] IO_OE,
   output logic                 REG_CLEAR,
   output logic                 USER_MODE,
   output logic                 STATUS_PIN_AS_USER_IO,
   output logic                 OVERRIDE_PIN_AS_USER_IO,
   output logic                 CLEAR_PIN_AS_USER_IO
);


   // Filtered board pin levels
   logic                            startup_clk_filt;
   logic                            override_n_filt;
   logic                            clear_n_filt;
   logic                            status_pin_filt;
   // Start-up clock edge detection
   logic                            startup_clk_prev;
   logic                            startup_step;
   logic                            init_step;
   // Sequencer state and counter
   isgo_pkg::isgo_state_e           state;
   isgo_pkg::isgo_state_e           next_state;
   logic [isgo_pkg::INIT_CNT_W-1:0] init_cnt;
   logic [isgo_pkg::INIT_CNT_W-1:0] next_init_cnt;
   logic                            init_last;
   logic                            cal_ready;
   // Raw board pins, one synchroniser each
   logic [3:0]                      pin_raw;

   // States in which the status pin is pulled low
   function automatic logic status_drive(input isgo_pkg::isgo_state_e st);
      status_drive = (st == isgo_pkg::ST_INIT) || (st == isgo_pkg::ST_CAL_WAIT);
   endfunction

   // Board pins gathered for the synchronisers
   assign pin_raw = {INIT_STATUS_IN, GLOBAL_REGISTER_CLEAR_N,
                     GLOBAL_OUTPUT_OVERRIDE_N, USER_STARTUP_CLOCK};

   // Three-stage synchroniser and agreement filter per pin
   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_sync
         logic [2:0] stage;
         logic       filt;
         // Shift chain; only the second stage reads the first
         always_ff @(posedge CLK_SYS)
         begin
            if (!RESET_N)
            begin
               stage <= isgo_pkg::SYNC_RESET;
            end
            else
            begin
               stage <= {stage[1:0], pin_raw[g]};
            end
         end
         // Level accepted once the two late stages agree
         always_ff @(posedge CLK_SYS)
         begin
            if (!RESET_N)
            begin
               filt <= 1'b1;
            end
            else if (stage[1] == stage[2])
            begin
               filt <= stage[2];
            end
         end
      end
   endgenerate

   // Named views of the filtered pins
   assign startup_clk_filt = g_sync[0].filt;
   assign override_n_filt  = g_sync[1].filt;
   assign clear_n_filt     = g_sync[2].filt;
   assign status_pin_filt  = g_sync[3].filt;

   // Previous start-up clock level; resets high so no false edge
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         startup_clk_prev <= 1'b1;
      end
      else
      begin
         startup_clk_prev <= startup_clk_filt;
      end
   end

   // Initialization steps on start-up clock edges when that option is on
   assign startup_step = startup_clk_filt && !startup_clk_prev;
   assign init_step    = OPT_STARTUP_CLK_EN ? startup_step : 1'b1;
   assign init_last    = init_step && (init_cnt == isgo_pkg::INIT_CYCLES - 8'h01);
   // Calibration only matters with the gating option set
   assign cal_ready    = !OPT_CAL_GATE_EN || TERMINATION_CALIBRATED;

   // Sequencer next state
   always_comb
   begin
      next_state = state;
      if (!CONFIG_RESTART_N)
      begin
         next_state = isgo_pkg::ST_RESTART;
      end
      else
      begin
         unique case (state)
            isgo_pkg::ST_RESTART:
            begin
               next_state = isgo_pkg::ST_LOAD;
            end
            isgo_pkg::ST_LOAD:
            begin
               if (FIRST_FRAME_LOADED)
               begin
                  next_state = isgo_pkg::ST_INIT;
               end
            end
            isgo_pkg::ST_INIT:
            begin
               if (init_last)
               begin
                  next_state = cal_ready ? isgo_pkg::ST_USER : isgo_pkg::ST_CAL_WAIT;
               end
            end
            isgo_pkg::ST_CAL_WAIT:
            begin
               if (cal_ready)
               begin
                  next_state = isgo_pkg::ST_USER;
               end
            end
            isgo_pkg::ST_USER:
            begin
               next_state = isgo_pkg::ST_USER;
            end
            default:
            begin
               next_state = isgo_pkg::ST_RESTART;
            end
         endcase
      end
   end

   // Initialization counter next value
   always_comb
   begin
      next_init_cnt = init_cnt;
      if (state != isgo_pkg::ST_INIT)
      begin
         next_init_cnt = isgo_pkg::INIT_CNT_RESET;
      end
      else if (init_step)
      begin
         next_init_cnt = init_cnt + 1'b1;
      end
   end

   // Sequencer state register
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         state <= isgo_pkg::ST_RESTART;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Initialization counter register
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         init_cnt <= isgo_pkg::INIT_CNT_RESET;
      end
      else
      begin
         init_cnt <= next_init_cnt;
      end
   end

   // Open-drain status pin: floats in restart, low while initializing
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         INIT_STATUS_OE  <= 1'b0;
         INIT_STATUS_OUT <= 1'b1;
      end
      else
      begin
         INIT_STATUS_OE  <= OPT_INIT_DONE_EN && status_drive(next_state);
         INIT_STATUS_OUT <= !(OPT_INIT_DONE_EN && status_drive(next_state));
      end
   end

   // User mode flag
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         USER_MODE <= 1'b0;
      end
      else
      begin
         USER_MODE <= (next_state == isgo_pkg::ST_USER);
      end
   end

   // Device-wide output override
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         IO_OE <= {N_IO{1'b0}};
      end
      else if (OPT_OVERRIDE_EN && !override_n_filt)
      begin
         IO_OE <= {N_IO{1'b0}};
      end
      else
      begin
         IO_OE <= USER_IO_OE;
      end
   end

   // Device-wide register clear
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         REG_CLEAR <= 1'b0;
      end
      else
      begin
         REG_CLEAR <= OPT_CLEAR_EN && !clear_n_filt;
      end
   end

   // Pins without their option serve as user I/O
   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         STATUS_PIN_AS_USER_IO   <= 1'b1;
         OVERRIDE_PIN_AS_USER_IO <= 1'b1;
         CLEAR_PIN_AS_USER_IO    <= 1'b1;
      end
      else
      begin
         STATUS_PIN_AS_USER_IO   <= !OPT_INIT_DONE_EN;
         OVERRIDE_PIN_AS_USER_IO <= !OPT_OVERRIDE_EN;
         CLEAR_PIN_AS_USER_IO    <= !OPT_CLEAR_EN;
      end
   end

   // Checks on the sequencer and pin roles
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);

   // First frame taken with the status option set
   sequence s_frame_taken;
      (state == isgo_pkg::ST_LOAD) && CONFIG_RESTART_N && FIRST_FRAME_LOADED && OPT_INIT_DONE_EN;
   endsequence

   // Status pin actively pulled low
   sequence s_status_low;
      INIT_STATUS_OE && !INIT_STATUS_OUT;
   endsequence

   a_restart_float: assert property (!CONFIG_RESTART_N |=> !INIT_STATUS_OE)
      else $error("status pin driven during restart");
   a_frame_drive: assert property (s_frame_taken |=> s_status_low)
      else $error("status pin not low after first frame");
   a_init_release: assert property ((state == isgo_pkg::ST_USER) |-> (!INIT_STATUS_OE && USER_MODE))
      else $error("status pin held in user mode");
   a_cal_gate: assert property (((state != isgo_pkg::ST_USER) && OPT_CAL_GATE_EN && !TERMINATION_CALIBRATED) |=> (state != isgo_pkg::ST_USER))
      else $error("user mode before calibration");
   a_override_off: assert property ((OPT_OVERRIDE_EN && !override_n_filt) |=> (IO_OE == {N_IO{1'b0}}))
      else $error("pins not tri-stated by override");
   a_clear_drive: assert property ((OPT_CLEAR_EN && !clear_n_filt) |=> REG_CLEAR)
      else $error("registers not cleared");
   a_status_role: assert property (!OPT_INIT_DONE_EN |=> (!INIT_STATUS_OE && STATUS_PIN_AS_USER_IO))
      else $error("status pin role wrong");
   a_startup_hold: assert property (((state == isgo_pkg::ST_INIT) && CONFIG_RESTART_N && OPT_STARTUP_CLK_EN && !startup_step) |=> $stable(init_cnt))
      else $error("init counted without start-up clock edge");

endmodule

// >>> isgo_board_mon.sv
`timescale 1ns/1ns
// Board pull-up and user-mode watcher
module isgo_board_mon
(
   // Status pin as driven by the device
   input  wire logic oe,
   input  wire logic d,
   // Pin level and user-mode flag
   output logic      pin,
   output logic      seen
);
   logic was_low;
   // Released pin rises on the pull-up
   assign pin = oe ? d : 1'b1;
   // Flags start clear
   initial
   begin
      was_low = 1'b0;
      seen = 1'b0;
   end
   // Only a real low-to-high edge marks user mode
   always @(negedge pin) was_low = 1'b1;
   always @(posedge pin) if (was_low) seen = 1'b1;
endmodule

// >>> init_status_and_global_overrides_tb_top.sv
`timescale 1ns/1ns
module init_status_and_global_overrides_tb_top;
   logic CLK_SYS=0, RESET_N=0, CONFIG_RESTART_N=0, FIRST_FRAME_LOADED=0, USER_STARTUP_CLOCK=0;
   logic TERMINATION_CALIBRATED=0, OPT_INIT_DONE_EN=1, OPT_CAL_GATE_EN=1, OPT_OVERRIDE_EN=1;
   logic OPT_CLEAR_EN=1, OPT_STARTUP_CLK_EN=1, GLOBAL_OUTPUT_OVERRIDE_N=1, GLOBAL_REGISTER_CLEAR_N=1;
   logic INIT_STATUS_IN, INIT_STATUS_OUT, INIT_STATUS_OE, REG_CLEAR, USER_MODE, seen;
   logic STATUS_PIN_AS_USER_IO, OVERRIDE_PIN_AS_USER_IO, CLEAR_PIN_AS_USER_IO;
   logic [7:0] USER_IO_OE=8'hFF, IO_OE;
   int bad_count=0, samples_checked=0, cyc=0;
   // Clocks and hang guard
   always #4 CLK_SYS = ~CLK_SYS;
   always #20 USER_STARTUP_CLOCK = ~USER_STARTUP_CLOCK;
   always @(posedge CLK_SYS) if (++cyc == 2000) tally_and_finish(1);
   isgo_init_status dut (.*);
   isgo_board_mon mon (.oe(INIT_STATUS_OE), .d(INIT_STATUS_OUT), .pin(INIT_STATUS_IN), .seen(seen));
   task step(int n); repeat (n) @(posedge CLK_SYS); #1; endtask
   task chk(string n, logic [8:0] s, e); samples_checked++;
      if (s !== e) bad_count++;
      if (s !== e) $display("wrong value %s: expected %h seen %h", n, e, s);
      $display("test %s done", n); endtask
   task tally_and_finish(int hang); bad_count += hang;
      $display("%0d checks, %0d mismatches", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish; endtask
   // Restart, load, calibration gate, overrides, options off
   initial
   begin
      step(16); RESET_N = 1; step(2); chk("pin in restart", INIT_STATUS_IN, 1);
      {CONFIG_RESTART_N, FIRST_FRAME_LOADED} = 2'h3; step(4); chk("pin after frame", INIT_STATUS_IN, 0);
      step(300); chk("pin before cal", INIT_STATUS_IN, 0);
      TERMINATION_CALIBRATED = 1; step(10); chk("user mode", {seen, USER_MODE}, 3);
      {GLOBAL_OUTPUT_OVERRIDE_N, GLOBAL_REGISTER_CLEAR_N} = 0; step(5); chk("overrides", {IO_OE, REG_CLEAR}, 1);
      {OPT_OVERRIDE_EN, OPT_CLEAR_EN} = 0; step(5); chk("options off", {IO_OE, REG_CLEAR}, 9'h1FE);
      chk("pin roles", {STATUS_PIN_AS_USER_IO, OVERRIDE_PIN_AS_USER_IO, CLEAR_PIN_AS_USER_IO}, 3);
      tally_and_finish(0);
   end
endmodule
